/* File: button_teach_menu_controller.sv */
`timescale 1ns/1ps
// Function
// - programming only in window after power-up
// - activity extends window; timeout locks until reset
// - button ignored while field link active
// - ten-second hold aborts, settings unchanged
// - wait group turn; peers standby then resume
// - two-second hold, brief press stores near
// - two holds store far point, confirm
// - yellow slow on target, fast without
// - red on unreliable detect; store only reliable
// - five-second hold opens menu, green flashes
// - menu stages mode, logic, beam; hold advances
// - brief press steps option; count shows it
// - switching variant green count gives mode
// - red count gives beam width
// - hold in beam stage commits all
// - analog field-link mode sticks until reset
// - power-up green on with stored presets
// - analog variant green count gives ramp/link
// - sync high over one second gives standby
module button_teach_menu_controller
  import btm_pkg::*;
#(
  parameter int MS_CYCLES = TICK_CYCLES,       // ref_clk cycles per ms
  parameter int WINDOW_MS = PROG_WINDOW_MS,    // programming window
  parameter int HOLD_T_MS = HOLD_MS,
  parameter int MENU_T_MS = MENU_MS,
  parameter int CANCEL_T_MS = CANCEL_MS,
  parameter int SYNC_T_MS = SYNC_MS,
  parameter int SLOT_MS = FLASH_SLOT_MS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic button,                     // high while pressed
  input wire logic link_active,                // field link communicating
  input wire logic sync_in,                    // synchronization input level
  input wire logic group_mode,                 // member of a synchronized group
  input wire logic group_turn,                 // this sensor's turn in group
  input wire logic is_analog,                  // analog-output variant
  input wire logic target_seen,                // echo found
  input wire logic detect_reliable,            // echo stable
  input wire logic switch_state,               // output state for yellow
  input wire logic [DIST_W-1:0] distance,      // current measured distance
  output logic led_green,
  output logic led_yellow,
  output logic led_red,
  output logic [DIST_W-1:0] near_switch_point,
  output logic [DIST_W-1:0] far_switch_point,
  output cfg_t cfg,                            // committed menu settings
  output logic field_link_mode,                // analog parameter mode latched
  output logic prog_busy,                      // programming in progress
  output logic standby,                        // standby from sync input
  output logic prog_locked                     // window expired
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (MS_CYCLES < 2 || HOLD_T_MS < 1 || MENU_T_MS <= HOLD_T_MS ||
      CANCEL_T_MS <= MENU_T_MS || SLOT_MS < 2 || WINDOW_MS < 1) begin : g_chk
    $error("timing parameters out of range");
  end

  localparam int MSC_W = $clog2(MS_CYCLES);
  localparam int WIN_W = $clog2(WINDOW_MS + 1);
  localparam int PRS_W = $clog2(CANCEL_T_MS + 1);
  localparam int SYN_W = $clog2(SYNC_T_MS + 2);
  localparam int SLT_W = $clog2(SLOT_MS);

  // lit slot of a burst of n flashes, then a dark gap
  function automatic logic flash_lit(input logic [3:0] slot, input logic [2:0] n);
    flash_lit = (slot < {n, 1'b0}) && !slot[0];
  endfunction

  // ----------------------------------------
  // millisecond tick
  // ----------------------------------------
  logic [MSC_W-1:0] ms_cnt; // cycle divider
  logic tick;               // one-cycle pulse per ms

  // divider makes the ms enable pulse
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ms_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (ms_cnt == MSC_W'(MS_CYCLES - 1));
      ms_cnt <= (ms_cnt == MSC_W'(MS_CYCLES - 1)) ? '0 : ms_cnt + 1'b1;
    end
  end

  // ----------------------------------------
  // programming window and button qualify
  // ----------------------------------------
  logic [WIN_W-1:0] win_ms; // ms since last activity
  logic btn_q;              // qualified button, last cycle
  logic [PRS_W-1:0] press_ms; // length of current press
  logic press_used;         // press already acted on
  state_t state;
  state_t next_state;

  wire btn_eff = button && !link_active && !prog_locked && !standby;
  wire press_start = btn_eff && !btn_q;
  wire release_ev = btn_q && !btn_eff && !press_used;
  wire ev_brief = release_ev && (press_ms < PRS_W'(HOLD_T_MS));
  wire ev_hold = release_ev && (press_ms >= PRS_W'(HOLD_T_MS));
  wire ev_teach = ev_hold && (press_ms < PRS_W'(MENU_T_MS));
  wire ev_menu = btn_eff && tick && !press_used && (press_ms == PRS_W'(MENU_T_MS - 1));
  wire ev_cancel = btn_eff && tick && (press_ms == PRS_W'(CANCEL_T_MS - 1));
  wire activity = press_start || release_ev;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      win_ms <= '0;
      prog_locked <= 1'b0;
    end else if (activity) begin
      win_ms <= '0;
    end else if (tick && !prog_locked && state == ST_IDLE) begin
      win_ms <= win_ms + 1'b1;
      if (win_ms == WIN_W'(WINDOW_MS - 1)) begin
        prog_locked <= 1'b1;
      end
    end
  end

  // press duration, saturating at the abort time
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      btn_q <= 1'b0;
      press_ms <= '0;
      press_used <= 1'b0;
    end else begin
      btn_q <= btn_eff;
      if (press_start) begin
        press_ms <= '0;
        press_used <= 1'b0;
      end else if (btn_eff && tick && press_ms != PRS_W'(CANCEL_T_MS)) begin
        press_ms <= press_ms + 1'b1;
      end
      if (ev_menu || ev_cancel) begin
        press_used <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // standby from sync input
  // ----------------------------------------
  logic [SYN_W-1:0] sync_ms; // ms sync has been high

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync_ms <= '0;
      standby <= 1'b0;
    end else if (!sync_in) begin
      sync_ms <= '0;
      standby <= 1'b0;
    end else if (tick && sync_ms != SYN_W'(SYNC_T_MS + 1)) begin
      sync_ms <= sync_ms + 1'b1;
      standby <= (sync_ms >= SYN_W'(SYNC_T_MS));
    end
  end

  // ----------------------------------------
  // sequence state machine
  // ----------------------------------------
  logic pend_menu; // menu waits for group turn
  cfg_t shadow;    // menu selections not yet committed
  wire [1:0] mode_last = is_analog ? AN_MODE_LAST : SW_MODE_LAST;
  wire burst_done;
  wire want_start = ev_teach || ev_menu;
  wire start_ok = !group_mode || group_turn;

  // next state from button events
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (want_start) begin
          next_state = !start_ok ? ST_WAIT_TURN : (ev_menu ? ST_MENU_MODE : ST_TEACH);
        end
      end
      ST_WAIT_TURN: begin
        if (start_ok) begin
          next_state = pend_menu ? ST_MENU_MODE : ST_TEACH;
        end
      end
      ST_TEACH: begin
        if (ev_brief || ev_hold) begin
          next_state = detect_reliable ? ST_CONFIRM : ST_WARN;
        end
      end
      ST_MENU_MODE: next_state = ev_hold ? ST_MENU_LOGIC : state;
      ST_MENU_LOGIC: next_state = ev_hold ? ST_MENU_BEAM : state;
      ST_MENU_BEAM: next_state = ev_hold ? ST_IDLE : state;
      ST_CONFIRM, ST_WARN: next_state = burst_done ? ST_IDLE : state;
      default: next_state = ST_IDLE;
    endcase
    if (ev_cancel && state != ST_IDLE) begin
      next_state = ST_IDLE;
    end
  end

  // state register and pending target
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      pend_menu <= 1'b0;
      prog_busy <= 1'b0;
    end else begin
      state <= next_state;
      prog_busy <= (next_state != ST_IDLE);
      if (state == ST_IDLE && want_start) begin
        pend_menu <= ev_menu;
      end
    end
  end

  // ----------------------------------------
  // taught points and menu settings
  // ----------------------------------------
  // stores happen only on completed sequences
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      near_switch_point <= '0;
      far_switch_point <= '0;
      shadow <= CFG_RESET;
      cfg <= CFG_RESET;
      field_link_mode <= 1'b0;
    end else begin
      if (state == ST_TEACH && ev_brief && detect_reliable && !ev_cancel) begin
        near_switch_point <= distance;
      end
      if (state == ST_TEACH && ev_hold && detect_reliable && !ev_cancel) begin
        far_switch_point <= distance;
      end
      // menu starts from the committed settings
      if (next_state == ST_MENU_MODE && state != ST_MENU_MODE) begin
        shadow <= cfg;
      end
      if (ev_brief) begin
        case (state)
          ST_MENU_MODE: shadow.out_mode <= (shadow.out_mode >= mode_last) ? 2'h0
                                           : shadow.out_mode + 2'h1;
          ST_MENU_LOGIC: shadow.out_logic <= !shadow.out_logic;
          ST_MENU_BEAM: shadow.beam <= (shadow.beam >= BEAM_LAST) ? 2'h0
                                       : shadow.beam + 2'h1;
          default: ;
        endcase
      end
      if (state == ST_MENU_BEAM && ev_hold && !ev_cancel) begin
        cfg <= shadow;
        if (is_analog && shadow.out_mode == AN_LINK_MODE) begin
          field_link_mode <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // flash count generator
  // ----------------------------------------
  logic [SLT_W-1:0] slot_ms; // ms within slot
  logic [3:0] slot;          // slot in burst
  logic [BLINK_W-1:0] blink; // free blink counter
  logic [2:0] flash_n;       // flashes per burst
  wire restart = (next_state != state);
  wire slot_end = tick && (slot_ms == SLT_W'(SLOT_MS - 1));
  wire [3:0] slot_wrap = 4'({flash_n, 1'b0}) + 4'(FLASH_GAP_SLOTS - 1);
  assign burst_done = slot_end && (slot == 4'({CONFIRM_FLASHES, 1'b0}));
  wire lit = flash_lit(slot, flash_n);

  // count shown for the current state
  always_comb begin
    case (state)
      ST_MENU_MODE: flash_n = 3'(shadow.out_mode) + 3'h1;
      ST_MENU_LOGIC: flash_n = {2'h0, shadow.out_logic} + 3'h1;
      ST_MENU_BEAM: flash_n = 3'(shadow.beam) + 3'h1;
      default: flash_n = CONFIRM_FLASHES;
    endcase
  end

  // slot timing restarts on every state change
  always_ff @(posedge ref_clk) begin
    if (!rst_n || restart) begin
      slot_ms <= '0;
      slot <= 4'h0;
    end else if (slot_end) begin
      slot_ms <= '0;
      slot <= (slot >= slot_wrap) ? 4'h0 : slot + 4'h1;
    end else if (tick) begin
      slot_ms <= slot_ms + 1'b1;
    end
  end

  // free blink source for slow and fast flashing
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      blink <= '0;
    end else if (tick) begin
      blink <= blink + 1'b1;
    end
  end

  // ----------------------------------------
  // led drive
  // ----------------------------------------
  leds_t next_leds;

  // led pattern per state
  always_comb begin
    next_leds = '{green: 1'b0, yellow: 1'b0, red: 1'b0};
    case (state)
      ST_IDLE, ST_WAIT_TURN: begin
        next_leds.green = standby ? blink[SLOW_BIT] : 1'b1;
        next_leds.yellow = switch_state;
      end
      ST_TEACH: begin
        if (!detect_reliable) begin
          next_leds.red = blink[SLOW_BIT];
        end else begin
          next_leds.yellow = target_seen ? blink[SLOW_BIT] : blink[FAST_BIT];
        end
      end
      ST_MENU_MODE: next_leds.green = lit;
      ST_MENU_LOGIC: next_leds.yellow = lit;
      ST_MENU_BEAM: next_leds.red = lit;
      ST_CONFIRM: next_leds.green = lit;
      ST_WARN: next_leds.red = lit;
      default: next_leds = '{green: 1'b0, yellow: 1'b0, red: 1'b0};
    endcase
  end

  // registered led outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      led_green <= 1'b0;
      led_yellow <= 1'b0;
      led_red <= 1'b0;
    end else begin
      led_green <= next_leds.green;
      led_yellow <= next_leds.yellow;
      led_red <= next_leds.red;
    end
  end

endmodule // button_teach_menu_controller

/* File: btm_pkg.sv */
package btm_pkg;

  // ----------------------------------------
  // clock and time base
  // ----------------------------------------
  localparam int CLK_HZ = 100_000_000;           // ref_clk rate
  localparam int MS_PER_S = 1000;
  localparam int TICK_MS = 1;                    // time base step, ms
  localparam int TICK_CYCLES = CLK_HZ / MS_PER_S * TICK_MS;

  // ----------------------------------------
  // button and window timing, in ms
  // ----------------------------------------
  localparam int PROG_WINDOW_MIN = 5;            // programming window
  localparam int PROG_WINDOW_MS = PROG_WINDOW_MIN * 60 * MS_PER_S;
  localparam int HOLD_S = 2;                     // hold threshold
  localparam int HOLD_MS = HOLD_S * MS_PER_S;
  localparam int MENU_S = 5;                     // menu entry hold
  localparam int MENU_MS = MENU_S * MS_PER_S;
  localparam int CANCEL_S = 10;                  // abort hold
  localparam int CANCEL_MS = CANCEL_S * MS_PER_S;
  localparam int SYNC_S = 1;                     // standby when sync high longer
  localparam int SYNC_MS = SYNC_S * MS_PER_S;

  // ----------------------------------------
  // led patterns
  // ----------------------------------------
  localparam int FLASH_SLOT_MS = 250;            // one on or off slot of a count
  localparam int FLASH_GAP_SLOTS = 4;            // dark slots after a burst's last off slot
  localparam logic [2:0] CONFIRM_FLASHES = 3'h3; // confirm or warn burst
  localparam int BLINK_W = 10;                   // free blink counter width
  localparam int SLOW_BIT = 9;                   // slow blink, about 1 Hz
  localparam int FAST_BIT = 7;                   // fast blink, about 4 Hz

  // ----------------------------------------
  // menu option counts and codes
  // ----------------------------------------
  localparam logic [1:0] SW_MODE_LAST = 2'h3;    // switch, window, hyst, retro
  localparam logic [1:0] AN_MODE_LAST = 2'h2;    // rising, falling, field link
  localparam logic [1:0] AN_LINK_MODE = 2'h2;    // field-link parameter mode
  localparam logic [1:0] BEAM_LAST = 2'h2;       // small, medium, wide
  localparam int DIST_W = 16;                    // taught distance width

  // selections of the mode menu
  typedef struct packed {
    logic [1:0] out_mode;   // 0 first option
    logic out_logic;        // 0 normally-open / current
    logic [1:0] beam;       // 0 small
  } cfg_t;

  localparam cfg_t CFG_RESET = '{out_mode: 2'h0, out_logic: 1'b0, beam: 2'h1};

  // led drive bundle
  typedef struct packed {
    logic green;
    logic yellow;
    logic red;
  } leds_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_TURN, ST_TEACH, ST_MENU_MODE, ST_MENU_LOGIC, ST_MENU_BEAM,
    ST_CONFIRM, ST_WARN
  } state_t;

endpackage

/* File: btm_checker_sva.sv */
`timescale 1ns/1ps
module btm_checker
  import btm_pkg::*;
#(
  parameter int MS_CYCLES = 4,
  parameter int MENU_T_MS = 8,
  parameter int CANCEL_T_MS = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic button,
  input wire logic link_active,
  input wire logic sync_in,
  input wire logic detect_reliable,
  input wire logic [DIST_W-1:0] distance,
  input wire logic led_green,
  input wire logic [DIST_W-1:0] near_switch_point,
  input wire logic [DIST_W-1:0] far_switch_point,
  input wire cfg_t cfg,
  input wire logic field_link_mode,
  input wire logic prog_busy,
  input wire logic standby,
  input wire logic prog_locked
);
  // ----------------------------------------
  // hold counters
  // ----------------------------------------
  logic [15:0] idle_hold; // qualified press length while idle
  logic [15:0] busy_hold; // press length while programming
  // count consecutive cycles of each kind of hold
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      idle_hold <= '0;
      busy_hold <= '0;
    end else begin
      idle_hold <= (button && !prog_busy && !link_active && !prog_locked && !standby)
        ? idle_hold + 16'h1 : '0;
      busy_hold <= (button && prog_busy) ? busy_hold + 16'h1 : '0;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  locked_sticky_a: assert property (prog_locked |=> prog_locked)
    else $error("lock dropped");
  link_sticky_a: assert property (field_link_mode |=> field_link_mode)
    else $error("field link mode dropped");
  cfg_commit_a: assert property (!$stable(cfg) |-> $past(prog_busy))
    else $error("settings changed outside programming");
  near_store_a: assert property (!$stable(near_switch_point) |->
    $past(detect_reliable) && $past(prog_busy) && near_switch_point == $past(distance))
    else $error("near point stored wrongly");
  far_store_a: assert property (!$stable(far_switch_point) |->
    $past(detect_reliable) && $past(prog_busy) && far_switch_point == $past(distance))
    else $error("far point stored wrongly");
  link_block_a: assert property ((link_active && !prog_busy)[*3] |=> !prog_busy)
    else $error("programming started during link traffic");
  sync_drop_a: assert property (!sync_in[*2] |=> !standby)
    else $error("standby without sync level");
  menu_open_a: assert property (idle_hold == 16'((MENU_T_MS + 3) * MS_CYCLES) |-> prog_busy)
    else $error("long hold did not open menu");
  cancel_hold_a: assert property (busy_hold == 16'((CANCEL_T_MS + 2) * MS_CYCLES) |-> !prog_busy)
    else $error("long hold did not abort");
  idle_green_a: assert property ((!prog_busy && !standby && !field_link_mode)[*3] |-> led_green)
    else $error("green not lit in normal operation");
endmodule // btm_checker

/* File: button_operator.sv */
`timescale 1ns/1ps
// person at the push button; presses are whole milliseconds
module button_operator #(
  parameter int MS_CYCLES = 4
) (
  input wire logic ref_clk,
  output logic button
);
  initial button = 1'b0;
  // press for ms milliseconds, then leave a 3 ms pause
  task automatic press(input int ms);
    @(posedge ref_clk);
    #1 button = 1'b1;
    repeat (ms * MS_CYCLES) @(posedge ref_clk);
    #1 button = 1'b0;
    repeat (3 * MS_CYCLES) @(posedge ref_clk);
    #1;
  endtask
endmodule // button_operator

/* File: button_teach_menu_controller_tb_top.sv */
`timescale 1ns/1ps
module button_teach_menu_controller_tb_top;
  import btm_pkg::*;
  localparam int MSC = 4; // cycles per ms
  logic ref_clk, rst_n, link_active, sync_in, group_mode, group_turn, is_analog;
  logic target_seen, detect_reliable, switch_state;
  logic [DIST_W-1:0] distance, near_switch_point, far_switch_point;
  logic led_green, led_yellow, led_red, field_link_mode, prog_busy, standby, prog_locked;
  wire button;
  cfg_t cfg;
  logic [2:0] leds; // green, yellow, red
  int failures, comparisons, n;
  assign leds = {led_green, led_yellow, led_red};
  button_teach_menu_controller #(.MS_CYCLES(MSC), .WINDOW_MS(200), .HOLD_T_MS(4),
    .MENU_T_MS(8), .CANCEL_T_MS(16), .SYNC_T_MS(3), .SLOT_MS(2))
  button_teach_menu_controller_inst (.ref_clk(ref_clk), .rst_n(rst_n), .button(button),
    .link_active(link_active), .sync_in(sync_in), .group_mode(group_mode),
    .group_turn(group_turn), .is_analog(is_analog), .target_seen(target_seen),
    .detect_reliable(detect_reliable), .switch_state(switch_state), .distance(distance),
    .led_green(led_green), .led_yellow(led_yellow), .led_red(led_red),
    .near_switch_point(near_switch_point), .far_switch_point(far_switch_point), .cfg(cfg),
    .field_link_mode(field_link_mode), .prog_busy(prog_busy), .standby(standby),
    .prog_locked(prog_locked));
  button_operator #(.MS_CYCLES(MSC)) button_operator_inst (.ref_clk(ref_clk), .button(button));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // wait n edges, then step just past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    cyc(5);
    rst_n = 1'b1;
    cyc(2);
  endtask
  // bounded wait for return to normal operation
  task automatic wait_idle;
    int i;
    i = 0;
    while (prog_busy !== 1'b0 && i < 4000) begin
      cyc(1);
      i++;
    end
    chk(prog_busy, 0);
  endtask
  // count pulses of one burst on the masked led
  task automatic flashes(input logic [2:0] m, output int cnt);
    int d, k;
    logic prev;
    d = 0;
    k = 0;
    cnt = 0;
    prev = 1'b0;
    while (d < 20 && k < 3000) begin
      cyc(1);
      k++;
      d = ((leds & m) == 3'h0) ? d + 1 : 0;
    end
    d = 0;
    while ((d < 20 || cnt == 0) && k < 3000) begin
      cyc(1);
      k++;
      if ((leds & m) != 3'h0) begin
        if (!prev) cnt++;
        d = 0;
      end else d++;
      prev = ((leds & m) != 3'h0);
    end
  endtask
  // count level changes of the masked leds over a span of cycles
  task automatic toggles(input logic [2:0] m, input int span, output int cnt);
    logic prev;
    prev = ((leds & m) != 3'h0);
    cnt = 0;
    repeat (span) begin
      cyc(1);
      if (((leds & m) != 3'h0) != prev) cnt++;
      prev = ((leds & m) != 3'h0);
    end
  endtask
  task automatic conclude;
    $display("counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    failures = 0;
    comparisons = 0;
    rst_n = 1'b0;
    {link_active, sync_in, group_mode, group_turn, is_analog, switch_state} = 6'h00;
    {target_seen, detect_reliable} = 2'h3;
    distance = 16'h0123;
    do_reset;
    chk({11'h0, cfg}, {11'h0, CFG_RESET});
    chk(led_green, 1);
    switch_state = 1'b1;
    cyc(2);
    chk(led_yellow, 1);
    switch_state = 1'b0;
    cyc(2);
    chk(led_yellow, 0);
    $display("test reset done");
    button_operator_inst.press(6);
    chk(prog_busy, 1);
    toggles(3'h2, (1 << (SLOW_BIT + 1)) * MSC, n);
    chk(n, 2);
    target_seen = 1'b0;
    cyc(2);
    toggles(3'h2, (1 << (SLOW_BIT + 1)) * MSC, n);
    chk(n, 2 << (SLOW_BIT - FAST_BIT));
    target_seen = 1'b1;
    cyc(2);
    button_operator_inst.press(1);
    wait_idle;
    chk(near_switch_point, 16'h0123);
    distance = 16'h0456;
    button_operator_inst.press(6);
    button_operator_inst.press(6);
    wait_idle;
    chk(far_switch_point, 16'h0456);
    detect_reliable = 1'b0;
    button_operator_inst.press(6);
    button_operator_inst.press(1);
    n = 0;
    repeat (100) begin
      cyc(1);
      if (led_red === 1'b1) n = 1;
    end
    chk(n, 1);
    wait_idle;
    chk(near_switch_point, 16'h0123);
    detect_reliable = 1'b1;
    $display("test teach done");
    button_operator_inst.press(10);
    flashes(3'h4, n);
    chk(n, 1);
    repeat (3) button_operator_inst.press(1);
    flashes(3'h4, n);
    chk(n, 4);
    chk({11'h0, cfg}, {11'h0, CFG_RESET});
    button_operator_inst.press(6);
    button_operator_inst.press(1);
    flashes(3'h2, n);
    chk(n, 2);
    button_operator_inst.press(6);
    repeat (2) button_operator_inst.press(1);
    flashes(3'h1, n);
    chk(n, 1);
    button_operator_inst.press(6);
    wait_idle;
    // retroreflective, normally-closed, small
    chk({11'h0, cfg}, 16'h001c);
    button_operator_inst.press(10);
    button_operator_inst.press(1);
    button_operator_inst.press(20);
    wait_idle;
    chk({11'h0, cfg}, 16'h001c);
    $display("test menu done");
    is_analog = 1'b1;
    do_reset;
    button_operator_inst.press(10);
    repeat (3) button_operator_inst.press(1);
    flashes(3'h4, n);
    chk(n, 1);
    repeat (2) button_operator_inst.press(1);
    flashes(3'h4, n);
    chk(n, 3);
    repeat (3) button_operator_inst.press(6);
    wait_idle;
    chk(field_link_mode, 1);
    chk({11'h0, cfg}, 16'h0011);
    is_analog = 1'b0;
    do_reset;
    chk(field_link_mode, 0);
    $display("test analog done");
    link_active = 1'b1;
    button_operator_inst.press(10);
    chk(prog_busy, 0);
    link_active = 1'b0;
    group_mode = 1'b1;
    distance = 16'h0abc;
    button_operator_inst.press(6);
    cyc(40);
    chk(prog_busy, 1);
    chk(near_switch_point, 16'h0000);
    group_turn = 1'b1;
    cyc(8);
    button_operator_inst.press(1);
    wait_idle;
    chk(near_switch_point, 16'h0abc);
    group_mode = 1'b0;
    sync_in = 1'b1;
    cyc(6 * MSC);
    chk(standby, 1);
    toggles(3'h4, (1 << (SLOW_BIT + 1)) * MSC, n);
    chk(n, 2);
    button_operator_inst.press(10);
    chk(prog_busy, 0);
    sync_in = 1'b0;
    cyc(8);
    chk(standby, 0);
    $display("test link group standby done");
    do_reset;
    cyc(150 * MSC);
    button_operator_inst.press(1);
    cyc(150 * MSC);
    chk(prog_locked, 0);
    cyc(70 * MSC);
    chk(prog_locked, 1);
    button_operator_inst.press(10);
    chk(prog_busy, 0);
    $display("test window done");
    conclude;
  end
  // cut a hang short
  initial begin
    #800000;
    failures++;
    conclude;
  end
endmodule // button_teach_menu_controller_tb_top
bind button_teach_menu_controller btm_checker #(.MS_CYCLES(MS_CYCLES), .MENU_T_MS(MENU_T_MS),
  .CANCEL_T_MS(CANCEL_T_MS)) btm_checker_inst (.ref_clk(ref_clk), .rst_n(rst_n),
  .button(button), .link_active(link_active), .sync_in(sync_in),
  .detect_reliable(detect_reliable), .distance(distance), .led_green(led_green),
  .near_switch_point(near_switch_point), .far_switch_point(far_switch_point), .cfg(cfg),
  .field_link_mode(field_link_mode), .prog_busy(prog_busy), .standby(standby),
  .prog_locked(prog_locked));
